// >>> verilog/fault_flags_pkg.sv
// Constants, register map and field layout of the fault and interrupt flag block.
// Assumes one 125 MHz system clock and a byte-wide parallel register port.
// Contract
// RULE_01 - Latch-off flags stay set; write 1 clears only once fault is gone.
// RULE_02 - Thermal shutdown sets latch status bit 4.
// RULE_03 - Overvoltage or short circuit sets per-channel latch bits 3..0.
// RULE_04 - Register 0x0D bits 3..0 show live per-channel power-good.
// RULE_05 - Live button bit 6 reads 1 only after 100 ns held press.
// RULE_06 - Button live bit and button flag work only in on/off switch mode.
// RULE_07 - Interrupt pin goes low while any unmasked interrupt flag is set.
// RULE_08 - Interrupt flags persist; write 1 clears one, all enables low clears all.
// RULE_09 - Power-good fail flags suppressed during initialization and normal shutdown.
// RULE_10 - Overheat above threshold sets interrupt flag bit 5.
// RULE_11 - Input supply below threshold sets interrupt flag bit 4.
// RULE_12 - Power-good failure sets per-channel interrupt flag bits 3..0.
// RULE_13 - Detected button press sets interrupt flag bit 6 until cleared.
// RULE_14 - Host reads 0x0E after interrupt, then writes 1 to clear flags.
// RULE_15 - Mask register 0x0F: 1 lets event drive the pin, 0 default blocks.
// RULE_16 - Overheat threshold code 00 disables the overheat flag.
// RULE_17 - Low-supply threshold code 1111 disables the low-supply flag.
// RULE_18 - Writing 0 or to reserved bits changes nothing; reserved bits read 0.
// RULE_19 - Interrupt pin is open-drain and releases once unmasked flags clear.

package fault_flags_pkg;

  localparam int unsigned CHAN_COUNT = 4;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 8;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LATCH_OFF_STATUS_OFS       = 8'h0C;
  localparam logic [ADDR_W-1:0] LIVE_STATUS_READBACK_OFS   = 8'h0D;
  localparam logic [ADDR_W-1:0] INTERRUPT_EVENT_STATUS_OFS = 8'h0E;
  localparam logic [ADDR_W-1:0] INTERRUPT_MASK_OFS         = 8'h0F;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned LATCH_TSD_BIT   = 4;
  localparam int unsigned LATCH_CHAN_LSB  = 0;
  localparam int unsigned LIVE_PG_LSB     = 0;
  localparam int unsigned LIVE_BUTTON_BIT = 6;
  localparam int unsigned INT_BUTTON_BIT  = 6;
  localparam int unsigned INT_TEMP_BIT    = 5;
  localparam int unsigned INT_LVIN_BIT    = 4;
  localparam int unsigned INT_PG_LSB      = 0;
  localparam int unsigned LATCH_FLAG_W    = 5;
  localparam int unsigned INT_FLAG_W      = 7;

  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0]       REG_ZERO         = 8'h00;
  localparam logic [INT_FLAG_W-1:0]   INT_MASK_RESET   = 7'h00;
  localparam logic [1:0]              TEMP_CODE_OFF    = 2'h0;
  localparam logic [3:0]              LVIN_CODE_OFF    = 4'hF;
  localparam logic [CHAN_COUNT-1:0]   ALL_CHAN_OFF     = 4'h0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned DEBOUNCE_NS     = 100;
  localparam int unsigned DEBOUNCE_CYCLES =
    (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : fault_flags_pkg

// >>> verilog/sticky_flag_bank.sv
// Bank of sticky flags: hardware set, software clear, set wins over clear.
// Assumes set and clear vectors are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module sticky_flag_bank #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clear_bits,
  output logic      [WIDTH-1:0] flags_reg
);

  if (WIDTH < 1) begin : g_bad_width
    $error("sticky_flag_bank needs WIDTH of at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clear_bits) | set_bits;
    end
  end

endmodule : sticky_flag_bank

`default_nettype wire

// >>> verilog/button_debounce.sv
// Hold-time debouncer: output rises after the input has stayed high HOLD_CYCLES clocks.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

module button_debounce #(
  parameter int unsigned HOLD_CYCLES = 13
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic level_in,
  output logic      stable_reg
);

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

  logic [CNT_W-1:0] hold_cnt_reg;

  if (HOLD_CYCLES < 1) begin : g_bad_hold
    $error("button_debounce needs HOLD_CYCLES of at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !level_in) begin
      hold_cnt_reg <= '0;
      stable_reg   <= 1'b0;
    end else if (hold_cnt_reg == CNT_W'(HOLD_CYCLES - 1)) begin
      stable_reg   <= 1'b1;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + CNT_W'(1);
    end
  end

endmodule : button_debounce

`default_nettype wire

// >>> verilog/fault_status_interrupt_flags.sv
// Latch-off status, live status, interrupt status and mask registers with open-drain interrupt.
// Assumes event inputs are synchronous pulses or levels from the analog fault detectors.
`timescale 1ns/1ps
`default_nettype none

module fault_status_interrupt_flags
  import fault_flags_pkg::*;
#(
  parameter int unsigned DEBOUNCE_HOLD = DEBOUNCE_CYCLES
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic [DATA_W-1:0]     reg_wr_data,
  input  wire logic                  reg_rd_en,
  output logic      [DATA_W-1:0]     reg_rd_data,
  input  wire logic                  thermal_shutdown_event,
  input  wire logic [CHAN_COUNT-1:0] overvoltage_event,
  input  wire logic [CHAN_COUNT-1:0] short_circuit_event,
  input  wire logic                  overheat_event,
  input  wire logic                  low_supply_event,
  input  wire logic [CHAN_COUNT-1:0] chan_power_good,
  input  wire logic                  pg_fail_suppress,
  input  wire logic                  manual_pushbutton_n,
  input  wire logic                  onoff_switch_mode,
  input  wire logic [CHAN_COUNT-1:0] channel_enable_inputs,
  input  wire logic [1:0]            overheat_threshold_code,
  input  wire logic [3:0]            low_supply_threshold_code,
  output logic                       int_n_o,
  output logic                       int_n_oe
);

  if (DEBOUNCE_HOLD < DEBOUNCE_CYCLES) begin : g_bad_debounce
    $error("DEBOUNCE_HOLD is shorter than the debounce interval");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ---------------------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------------------
  logic wr_latch;
  logic wr_int;
  logic wr_mask;

  assign wr_latch = reg_wr_en && hit(reg_addr, LATCH_OFF_STATUS_OFS);
  assign wr_int   = reg_wr_en && hit(reg_addr, INTERRUPT_EVENT_STATUS_OFS);
  assign wr_mask  = reg_wr_en && hit(reg_addr, INTERRUPT_MASK_OFS);

  // ---------------------------------------------------------------------------
  // Latch-off flags
  // ---------------------------------------------------------------------------
  logic [LATCH_FLAG_W-1:0] latch_fault_now;
  logic [LATCH_FLAG_W-1:0] latch_set;
  logic [LATCH_FLAG_W-1:0] latch_clear;
  logic [LATCH_FLAG_W-1:0] latch_flags;

  assign latch_fault_now[LATCH_TSD_BIT] = thermal_shutdown_event;                          // RULE_02

  for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan_latch
    assign latch_fault_now[LATCH_CHAN_LSB+ch] = overvoltage_event[ch]
                                              || short_circuit_event[ch];              // RULE_03
  end

  assign latch_set   = latch_fault_now;
  // Write-one clear, refused while the fault still stands
  assign latch_clear = wr_latch ? (reg_wr_data[LATCH_FLAG_W-1:0] & ~latch_fault_now)
                                : '0;                                                    // RULE_01 RULE_18

  sticky_flag_bank #(
    .WIDTH (LATCH_FLAG_W)
  ) u_latch_bank (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .set_bits   (latch_set),
    .clear_bits (latch_clear),
    .flags_reg  (latch_flags)
  );

  // ---------------------------------------------------------------------------
  // Button debounce and live status
  // ---------------------------------------------------------------------------
  logic btn_req;
  logic btn_stable;
  logic button_live_state;
  logic button_live_prev_reg;

  assign btn_req = !manual_pushbutton_n && onoff_switch_mode;                             // RULE_06

  button_debounce #(
    .HOLD_CYCLES (DEBOUNCE_HOLD)
  ) u_button_debounce (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .level_in   (btn_req),
    .stable_reg (btn_stable)
  );

  assign button_live_state = btn_stable && onoff_switch_mode;                             // RULE_05 RULE_06

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      button_live_prev_reg <= 1'b0;
    end else begin
      button_live_prev_reg <= button_live_state;
    end
  end

  // ---------------------------------------------------------------------------
  // Power-good failure detect
  // ---------------------------------------------------------------------------
  logic [CHAN_COUNT-1:0] pg_prev_reg;
  logic [CHAN_COUNT-1:0] pg_fail;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pg_prev_reg <= '0;
    end else begin
      pg_prev_reg <= chan_power_good;
    end
  end

  // Falling power-good is a failure unless start-up or shutdown expects it
  assign pg_fail = pg_prev_reg & ~chan_power_good & {CHAN_COUNT{!pg_fail_suppress}};     // RULE_09 RULE_12

  // ---------------------------------------------------------------------------
  // Interrupt flags
  // ---------------------------------------------------------------------------
  logic [INT_FLAG_W-1:0] int_set;
  logic [INT_FLAG_W-1:0] int_clear;
  logic [INT_FLAG_W-1:0] int_flags;
  logic                  all_disabled;

  assign int_set[INT_PG_LSB +: CHAN_COUNT] = pg_fail;                                      // RULE_12
  assign int_set[INT_LVIN_BIT] = low_supply_event
                              && (low_supply_threshold_code != LVIN_CODE_OFF);           // RULE_11 RULE_17
  assign int_set[INT_TEMP_BIT] = overheat_event
                              && (overheat_threshold_code != TEMP_CODE_OFF);             // RULE_10 RULE_16
  assign int_set[INT_BUTTON_BIT] = button_live_state && !button_live_prev_reg;            // RULE_13

  assign all_disabled = (channel_enable_inputs == ALL_CHAN_OFF);
  assign int_clear    = all_disabled ? '1
                      : wr_int ? reg_wr_data[INT_FLAG_W-1:0] : '0;                       // RULE_08 RULE_18

  sticky_flag_bank #(
    .WIDTH (INT_FLAG_W)
  ) u_int_bank (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .set_bits   (int_set),
    .clear_bits (int_clear),
    .flags_reg  (int_flags)
  );

  // ---------------------------------------------------------------------------
  // Interrupt mask and pin
  // ---------------------------------------------------------------------------
  logic [INT_FLAG_W-1:0] int_mask_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      int_mask_reg <= INT_MASK_RESET;
    end else if (wr_mask) begin
      int_mask_reg <= reg_wr_data[INT_FLAG_W-1:0];                                         // RULE_15
    end
  end

  // Open-drain: only ever drives low
  assign int_n_o  = 1'b0;                                                                  // RULE_19
  assign int_n_oe = |(int_flags & int_mask_reg);                                           // RULE_07 RULE_15 RULE_19

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = REG_ZERO;
    if (hit(reg_addr, LATCH_OFF_STATUS_OFS)) begin
      rd_mux[LATCH_FLAG_W-1:0] = latch_flags;
    end else if (hit(reg_addr, LIVE_STATUS_READBACK_OFS)) begin
      rd_mux[LIVE_PG_LSB +: CHAN_COUNT] = chan_power_good;                                 // RULE_04
      rd_mux[LIVE_BUTTON_BIT]           = button_live_state;                               // RULE_05
    end else if (hit(reg_addr, INTERRUPT_EVENT_STATUS_OFS)) begin
      rd_mux[INT_FLAG_W-1:0] = int_flags;
    end else if (hit(reg_addr, INTERRUPT_MASK_OFS)) begin
      rd_mux[INT_FLAG_W-1:0] = int_mask_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rd_data <= REG_ZERO;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_mux;                                                               // RULE_18
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_latch_hold: assert property ( // RULE_01
    latch_flags[LATCH_TSD_BIT] && !(wr_latch && reg_wr_data[LATCH_TSD_BIT])
    |=> latch_flags[LATCH_TSD_BIT])
    else $error("thermal latch flag dropped without a clear");

  chk_latch_fault_block: assert property ( // RULE_01
    wr_latch && reg_wr_data[LATCH_CHAN_LSB] && overvoltage_event[0]
    |=> latch_flags[LATCH_CHAN_LSB])
    else $error("latch flag cleared while fault present");

  chk_tsd_set: assert property ( // RULE_02
    thermal_shutdown_event |=> latch_flags[LATCH_TSD_BIT])
    else $error("thermal shutdown did not set latch flag");

  chk_chan_latch_set: assert property ( // RULE_03
    short_circuit_event[CHAN_COUNT-1] |=> latch_flags[LATCH_CHAN_LSB+CHAN_COUNT-1])
    else $error("short circuit did not set channel latch flag");

  chk_live_pg_read: assert property ( // RULE_04
    reg_rd_en && hit(reg_addr, LIVE_STATUS_READBACK_OFS)
    |=> reg_rd_data[LIVE_PG_LSB +: CHAN_COUNT] == $past(chan_power_good))
    else $error("live power-good readback wrong");

  chk_button_debounce: assert property ( // RULE_05
    $rose(button_live_state) |-> $past(btn_req, DEBOUNCE_CYCLES) && $past(btn_req, 1))
    else $error("button live bit rose before debounce interval");

  chk_button_mode: assert property ( // RULE_06
    !onoff_switch_mode && !int_flags[INT_BUTTON_BIT]
    |-> !button_live_state ##1 !int_flags[INT_BUTTON_BIT])
    else $error("button active outside on/off switch mode");

  chk_int_pin_low: assert property ( // RULE_07
    ((int_flags & int_mask_reg) != '0) |-> int_n_oe && !int_n_o)
    else $error("interrupt pin not driven low for unmasked flag");

  chk_int_clear_all: assert property ( // RULE_08
    all_disabled && (int_set == '0) |=> int_flags == '0)
    else $error("interrupt flags survive all channels disabled");

  chk_pg_suppress: assert property ( // RULE_09
    pg_fail_suppress && !int_flags[INT_PG_LSB] && !all_disabled
    && !(wr_int && reg_wr_data[INT_PG_LSB]) |=> !int_flags[INT_PG_LSB])
    else $error("power-good flag set while suppressed");

  chk_temp_off: assert property ( // RULE_16
    overheat_threshold_code == TEMP_CODE_OFF && !int_flags[INT_TEMP_BIT]
    |=> !int_flags[INT_TEMP_BIT])
    else $error("overheat flag set while warning disabled");

  chk_lvin_set: assert property ( // RULE_11
    low_supply_event && low_supply_threshold_code != LVIN_CODE_OFF
    |=> int_flags[INT_LVIN_BIT])
    else $error("low supply did not set its flag");

  chk_reserved_zero: assert property ( // RULE_18
    reg_rd_en |=> reg_rd_data[DATA_W-1] == 1'b0)
    else $error("reserved bit read as one");

  chk_pin_release: assert property ( // RULE_19
    ((int_flags & int_mask_reg) == '0) |-> !int_n_oe)
    else $error("interrupt pin held with no unmasked flag");

  chk_temp_set: assert property ( // RULE_10
    overheat_event && overheat_threshold_code != TEMP_CODE_OFF
    |=> int_flags[INT_TEMP_BIT])
    else $error("overheat did not set its flag");

  chk_pg_fail_set: assert property ( // RULE_12
    pg_prev_reg[0] && !chan_power_good[0] && !pg_fail_suppress
    |=> int_flags[INT_PG_LSB])
    else $error("power-good failure did not set its flag");

  chk_button_flag: assert property ( // RULE_13
    $rose(button_live_state) |=> int_flags[INT_BUTTON_BIT])
    else $error("button press did not set its flag");

  chk_mask_write: assert property ( // RULE_15
    wr_mask |=> int_mask_reg == $past(reg_wr_data[INT_FLAG_W-1:0]))
    else $error("interrupt mask write lost");

  chk_int_w1c: assert property ( // RULE_08
    wr_int && reg_wr_data[INT_TEMP_BIT] && !int_set[INT_TEMP_BIT]
    |=> !int_flags[INT_TEMP_BIT])
    else $error("overheat flag survived a write-one clear");

  chk_int_hold: assert property ( // RULE_08
    int_flags[INT_LVIN_BIT] && !all_disabled && !(wr_int && reg_wr_data[INT_LVIN_BIT])
    |=> int_flags[INT_LVIN_BIT])
    else $error("low supply flag dropped without a clear");

  cov_tsd_latched:  cover property (thermal_shutdown_event ##1 latch_flags[LATCH_TSD_BIT]);
  cov_button_flag:  cover property ($rose(int_flags[INT_BUTTON_BIT]));
  cov_pin_asserted: cover property ($rose(int_n_oe) ##[1:20] $fell(int_n_oe));
  cov_w1c_int:      cover property (wr_int && (reg_wr_data[INT_FLAG_W-1:0] & int_flags) != '0);

endmodule : fault_status_interrupt_flags

`default_nettype wire

// >>> verification/reg_host.sv
// Host processor model driving the byte-wide register port of the flag block.
// Assumes strobes are taken at the rising edge of sys_clk, read data valid one cycle later.
`timescale 1ns/1ps
`default_nettype none

module reg_host
  import fault_flags_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic                   reg_wr_en,
  output logic      [DATA_W-1:0] reg_wr_data,
  output logic                   reg_rd_en,
  input  wire logic [DATA_W-1:0] reg_rd_data
);
  initial begin
    reg_addr    = 8'h00;
    reg_wr_en   = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en   = 1'b0;
  end

  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en   <= 1'b0;
    // Released data bus does not keep its last value
    reg_wr_data <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask : read_reg

  // Interrupt service: find the cause, then clear exactly what was seen
  task automatic service_irq(output logic [DATA_W-1:0] f);
    read_reg(INTERRUPT_EVENT_STATUS_OFS, f);
    write_reg(INTERRUPT_EVENT_STATUS_OFS, f);
  endtask : service_irq
endmodule : reg_host
`default_nettype wire

// >>> verification/fault_status_interrupt_flags_test.sv
// Self-checking bench of the fault and interrupt flag block.
// Assumes the host model in reg_host.sv and the default debounce hold.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end

module fault_status_interrupt_flags_test;
  import fault_flags_pkg::*;

  logic                  sys_clk;
  logic                  srst      = 1'b1;
  logic [ADDR_W-1:0]     reg_addr;
  logic                  reg_wr_en;
  logic [DATA_W-1:0]     reg_wr_data;
  logic                  reg_rd_en;
  logic [DATA_W-1:0]     reg_rd_data;
  logic                  tsd_ev    = 1'b0;
  logic [CHAN_COUNT-1:0] ov_ev     = 4'h0;
  logic [CHAN_COUNT-1:0] sc_ev     = 4'h0;
  logic                  hot_ev    = 1'b0;
  logic                  low_ev    = 1'b0;
  logic [CHAN_COUNT-1:0] pg        = 4'h0;
  logic                  pg_supp   = 1'b0;
  logic                  button_n  = 1'b1;
  logic                  onoff     = 1'b0;
  logic [CHAN_COUNT-1:0] chan_en   = 4'hF;
  logic [1:0]            hot_code  = 2'h1;
  logic [3:0]            low_code  = 4'h0;
  logic                  int_n_o;
  logic                  int_n_oe;
  logic [DATA_W-1:0]     rd;
  int                    failures     = 0;
  int                    total_checks = 0;

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  reg_host u_reg_host (
    .sys_clk     (sys_clk),
    .reg_addr    (reg_addr),
    .reg_wr_en   (reg_wr_en),
    .reg_wr_data (reg_wr_data),
    .reg_rd_en   (reg_rd_en),
    .reg_rd_data (reg_rd_data)
  );

  fault_status_interrupt_flags u_fault_status_interrupt_flags (
    .sys_clk                   (sys_clk),
    .srst                      (srst),
    .reg_addr                  (reg_addr),
    .reg_wr_en                 (reg_wr_en),
    .reg_wr_data               (reg_wr_data),
    .reg_rd_en                 (reg_rd_en),
    .reg_rd_data               (reg_rd_data),
    .thermal_shutdown_event    (tsd_ev),
    .overvoltage_event         (ov_ev),
    .short_circuit_event       (sc_ev),
    .overheat_event            (hot_ev),
    .low_supply_event          (low_ev),
    .chan_power_good           (pg),
    .pg_fail_suppress          (pg_supp),
    .manual_pushbutton_n       (button_n),
    .onoff_switch_mode         (onoff),
    .channel_enable_inputs     (chan_en),
    .overheat_threshold_code   (hot_code),
    .low_supply_threshold_code (low_code),
    .int_n_o                   (int_n_o),
    .int_n_oe                  (int_n_oe)
  );

  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic t_reset_values;
    u_reg_host.read_reg(LATCH_OFF_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    u_reg_host.read_reg(INTERRUPT_MASK_OFS, rd);
    `CHK(rd, 8'h00)
    u_reg_host.read_reg(8'h20, rd);
    `CHK(rd, 8'h00)
    `CHK({int_n_oe, int_n_o}, 2'b00)
  endtask : t_reset_values

  task automatic t_latch_off;
    @(posedge sys_clk);
    tsd_ev <= 1'b1;
    ov_ev  <= 4'h1;
    sc_ev  <= 4'h8;
    u_reg_host.read_reg(LATCH_OFF_STATUS_OFS, rd);
    `CHK(rd, 8'h19)
    u_reg_host.write_reg(LATCH_OFF_STATUS_OFS, 8'hFF);
    u_reg_host.read_reg(LATCH_OFF_STATUS_OFS, rd);
    `CHK(rd, 8'h19)
    @(posedge sys_clk);
    tsd_ev <= 1'b0;
    ov_ev  <= 4'h0;
    sc_ev  <= 4'h0;
    u_reg_host.write_reg(LATCH_OFF_STATUS_OFS, 8'h00);
    u_reg_host.read_reg(LATCH_OFF_STATUS_OFS, rd);
    `CHK(rd, 8'h19)
    u_reg_host.write_reg(LATCH_OFF_STATUS_OFS, 8'hFF);
    u_reg_host.read_reg(LATCH_OFF_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
  endtask : t_latch_off

  task automatic t_live_status;
    @(posedge sys_clk);
    pg <= 4'hA;
    u_reg_host.read_reg(LIVE_STATUS_READBACK_OFS, rd);
    `CHK(rd, 8'h0A)
    u_reg_host.write_reg(LIVE_STATUS_READBACK_OFS, 8'hFF);
    u_reg_host.read_reg(LIVE_STATUS_READBACK_OFS, rd);
    `CHK(rd, 8'h0A)
  endtask : t_live_status

  task automatic t_pg_fail;
    @(posedge sys_clk);
    pg <= 4'hF;
    u_reg_host.write_reg(INTERRUPT_MASK_OFS, 8'h0A);
    u_reg_host.read_reg(INTERRUPT_MASK_OFS, rd);
    `CHK(rd, 8'h0A)
    @(posedge sys_clk);
    pg_supp <= 1'b1;
    pg      <= 4'h0;
    repeat (2) @(posedge sys_clk);
    pg_supp <= 1'b0;
    pg      <= 4'hF;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    @(posedge sys_clk);
    pg <= 4'h5;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h0A)
    `CHK({int_n_oe, int_n_o}, 2'b10)
    u_reg_host.write_reg(INTERRUPT_EVENT_STATUS_OFS, 8'h08);
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h02)
    `CHK(int_n_oe, 1'b1)
    u_reg_host.service_irq(rd);
    #1;
    `CHK(int_n_oe, 1'b0)
  endtask : t_pg_fail

  task automatic t_warnings;
    @(posedge sys_clk);
    hot_code <= 2'h0;
    low_code <= 4'hF;
    hot_ev   <= 1'b1;
    low_ev   <= 1'b1;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    @(posedge sys_clk);
    hot_code <= 2'h2;
    low_code <= 4'h3;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h30)
    `CHK(int_n_oe, 1'b0)
    @(posedge sys_clk);
    hot_ev <= 1'b0;
    low_ev <= 1'b0;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h30)
    @(posedge sys_clk);
    chan_en <= 4'h0;
    @(posedge sys_clk);
    chan_en <= 4'hF;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
  endtask : t_warnings

  task automatic t_button;
    @(posedge sys_clk);
    button_n <= 1'b0;
    pg       <= 4'hF;
    repeat (20) @(posedge sys_clk);
    u_reg_host.read_reg(LIVE_STATUS_READBACK_OFS, rd);
    `CHK(rd, 8'h0F)
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    @(posedge sys_clk);
    button_n <= 1'b1;
    onoff    <= 1'b1;
    u_reg_host.write_reg(INTERRUPT_MASK_OFS, 8'h4A);
    @(posedge sys_clk);
    button_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    u_reg_host.read_reg(LIVE_STATUS_READBACK_OFS, rd);
    `CHK(rd, 8'h0F)
    @(posedge sys_clk);
    button_n <= 1'b1;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h00)
    @(posedge sys_clk);
    button_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    u_reg_host.read_reg(LIVE_STATUS_READBACK_OFS, rd);
    `CHK(rd, 8'h4F)
    @(posedge sys_clk);
    button_n <= 1'b1;
    u_reg_host.read_reg(INTERRUPT_EVENT_STATUS_OFS, rd);
    `CHK(rd, 8'h40)
    `CHK({int_n_oe, int_n_o}, 2'b10)
    u_reg_host.service_irq(rd);
    #1;
    `CHK(int_n_oe, 1'b0)
  endtask : t_button

  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("Error %0t: run did not complete in time", $time);
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset_values();
    t_latch_off();
    t_live_status();
    t_pg_fail();
    t_warnings();
    t_button();
    end_of_test();
  end
endmodule : fault_status_interrupt_flags_test
`default_nettype wire
